// >>> include/igx_pkg.sv
// Shared constants and types for the 16-line serial GPIO expander.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package igx_pkg;
  // ****************************************************************
  // Clocking and serial bus limits
  // ****************************************************************
  localparam int CLK_HZ = 200_000_000; // System clock rate.
  localparam int SCL_MAX_HZ = 400_000; // Fastest bus clock supported.
  localparam int SCL_MIN_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ; // Cycles per bus bit.

  // ****************************************************************
  // Target address and command pointer layout
  // ****************************************************************
  localparam logic [3:0] ADDR_HI = 4'h4; // Fixed upper address bits, plain default.
  localparam int PTR_W = 3; // Pointer width; only the low three bits count.
  localparam logic [1:0] GRP_IN = 2'h0; // Pointer bits 2:1 for input registers.
  localparam logic [1:0] GRP_OUT = 2'h1; // Pointer bits 2:1 for output registers.
  localparam logic [1:0] GRP_POL = 2'h2; // Pointer bits 2:1 for polarity registers.
  localparam logic [1:0] GRP_CFG = 2'h3; // Pointer bits 2:1 for direction registers.

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] OUT_RST = 8'hFF; // Output latches.
  localparam logic [7:0] POL_RST = 8'h00; // Polarity inversion.
  localparam logic [7:0] CFG_RST = 8'hFF; // Direction: all inputs.
  localparam logic [PTR_W-1:0] PTR_RST = 3'h0; // Command pointer.
  localparam logic [2:0] LAST_BIT = 3'h7; // Bit count of the eighth bit.

  // Byte-level protocol states of the bus target.
  typedef enum logic [3:0] {
    IGX_IDLE, IGX_ADDR, IGX_ACK_ADDR, IGX_CMD, IGX_ACK_CMD,
    IGX_WDATA, IGX_ACK_WDATA, IGX_RDATA, IGX_RACK
  } igx_state_t;
endpackage

// >>> include/igx_pins_if.sv
// Interface carrying synchronised pin levels and bus events.
// Assumes both ends run on the system clock.
`timescale 1ns/100ps
interface igx_pins_if;
  logic scl; // Synchronised bus clock level.
  logic sda; // Synchronised bus data level.
  logic scl_rise; // One-cycle pulse on a rising bus clock.
  logic scl_fall; // One-cycle pulse on a falling bus clock.
  logic start; // One-cycle pulse on a start condition.
  logic stop; // One-cycle pulse on a stop condition.
  logic [7:0] pin_lo; // Synchronised low port lines.
  logic [7:0] pin_hi; // Synchronised high port lines.
  logic [2:0] strap; // Synchronised address straps.
  modport sync (output scl, sda, scl_rise, scl_fall, start, stop, pin_lo, pin_hi, strap);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop, pin_lo, pin_hi, strap);
endinterface

// >>> hdl/igx_pin_sync.sv
// Two-flop synchronisers for every pin, plus bus edge and condition detect.
// Assumes raw inputs are asynchronous to clk_sys_in.
`timescale 1ns/100ps
module igx_pin_sync (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [2:0] strap_in,
  input wire logic [7:0] pin_lo_in,
  input wire logic [7:0] pin_hi_in,
  igx_pins_if.sync p
);
  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic [20:0] meta_r; // First stage; read only by the second stage.
  logic [20:0] sync_r; // Second stage; the first value logic may use.
  logic scl_d_r; // Delayed bus clock for edge finding.
  logic sda_d_r; // Delayed bus data for condition finding.

  // Every pin passes two flops before comparison with stored values.
  always_ff @(posedge clk_sys_in) begin
    meta_r <= {scl_in, sda_in, strap_in, pin_lo_in, pin_hi_in};
    sync_r <= meta_r;
  end

  // Delay stage reads only the second flop, so edges see stable samples.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= sync_r[20];
      sda_d_r <= sync_r[19];
    end
  end

  // ****************************************************************
  // Decoded levels and events
  // ****************************************************************
  // Sampling at 200 MHz gives hundreds of samples per fast-mode bit.
  assign p.scl = sync_r[20];
  assign p.sda = sync_r[19];
  assign p.strap = sync_r[18:16];
  assign p.pin_lo = sync_r[15:8];
  assign p.pin_hi = sync_r[7:0];
  assign p.scl_rise = sync_r[20] & ~scl_d_r;
  assign p.scl_fall = ~sync_r[20] & scl_d_r;
  // Data moving while the clock is high marks start or stop.
  assign p.start = sync_r[20] & scl_d_r & ~sync_r[19] & sda_d_r;
  assign p.stop = sync_r[20] & scl_d_r & sync_r[19] & ~sda_d_r;
endmodule

// >>> hdl/igx_expander.sv
// Top of the 16-line serial GPIO expander: bus target, registers, interrupt.
// Assumes external pull-ups on the bus data and interrupt wires, and a
// bus master that never clocks faster than fast mode.
`timescale 1ns/100ps
module igx_expander (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o_out,
  output logic sda_oe_out,
  output logic int_o_out,
  output logic int_oe_out,
  input wire logic addr_strap_bit0_in,
  input wire logic addr_strap_bit1_in,
  input wire logic addr_strap_bit2_in,
  input wire logic [7:0] port_lo_in,
  output logic [7:0] port_lo_out,
  output logic [7:0] port_lo_oe_out,
  input wire logic [7:0] port_hi_in,
  output logic [7:0] port_hi_out,
  output logic [7:0] port_hi_oe_out
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  igx_pins_if pins ();
  igx_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .strap_in({addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in}),
    .pin_lo_in(port_lo_in),
    .pin_hi_in(port_hi_in),
    .p(pins.sync)
  );
  // ****************************************************************
  // State and register storage
  // ****************************************************************
  igx_pkg::igx_state_t state_r; // Byte-level protocol state.
  logic [2:0] cnt_r; // Bit count within the current byte.
  logic done_r; // Eighth bit of a byte has been clocked.
  logic [7:0] shift_r; // Shift register for both directions.
  logic [igx_pkg::PTR_W-1:0] ptr_r; // Command pointer, write only.
  logic mack_r; // Master acknowledged the last read byte.
  logic sda_oe_r; // Target pulls the data wire low.
  logic [7:0] out_r [2]; // Output latches, indexed by port.
  logic [7:0] pol_r [2]; // Polarity inversion, indexed by port.
  logic [7:0] cfg_r [2]; // Direction, 1 means input, indexed by port.
  logic [7:0] snap_r [2]; // Pin levels last handed to the master.
  logic init_r; // First cycle after reset: take the pin snapshot.
  logic int_r; // Interrupt line pulled low.
  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic [6:0] my_addr = {igx_pkg::ADDR_HI, pins.strap};
  wire logic addr_hit = (shift_r[7:1] == my_addr);
  wire logic is_read = shift_r[0];
  // Pointer bit 0 picks the port; a read ack already looks at the next byte's port.
  wire logic port_sel = (state_r == igx_pkg::IGX_RACK) ? ~ptr_r[0] : ptr_r[0];
  wire logic [1:0] grp_sel = ptr_r[2:1];
  wire logic [7:0] pin_sel = port_sel ? pins.pin_hi : pins.pin_lo;
  // Input register shows every pin regardless of direction.
  wire logic [7:0] in_val = pin_sel ^ pol_r[port_sel];
  wire logic [7:0] rd_byte = (grp_sel == igx_pkg::GRP_IN) ? in_val :
                             (grp_sel == igx_pkg::GRP_OUT) ? out_r[port_sel] :
                             (grp_sel == igx_pkg::GRP_POL) ? pol_r[port_sel] :
                             cfg_r[port_sel];
  // Pointer toggles within its register pair after each written data byte and each acknowledged read byte.
  wire logic [igx_pkg::PTR_W-1:0] ptr_next = {ptr_r[2:1], ~ptr_r[0]};
  wire logic in_state_byte = (state_r == igx_pkg::IGX_ADDR) || (state_r == igx_pkg::IGX_CMD) ||
                             (state_r == igx_pkg::IGX_WDATA) || (state_r == igx_pkg::IGX_RDATA);
  // Register write strobe at the falling edge ending a written data byte.
  wire logic wr_en = pins.scl_fall && done_r && (state_r == igx_pkg::IGX_WDATA);
  // Snapshot load when a read byte is fetched from an input register.
  wire logic load_rd = pins.scl_fall && (((state_r == igx_pkg::IGX_ACK_ADDR) && is_read) ||
                       ((state_r == igx_pkg::IGX_RACK) && mack_r));
  wire logic snap_ld = load_rd && (grp_sel == igx_pkg::GRP_IN);
  wire logic [15:0] mismatch = {pins.pin_hi ^ snap_r[1], pins.pin_lo ^ snap_r[0]};
  wire logic [15:0] mis_left = mismatch & ~{{8{snap_ld & port_sel}}, {8{snap_ld & ~port_sel}}};

  // ****************************************************************
  // Bit sampling on rising bus clock
  // ****************************************************************
  // Written bytes shift in here; read bytes only count, as they shift on fall.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || pins.start) begin
      cnt_r <= 3'h0;
      done_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (pins.scl_rise) begin
      if (in_state_byte) begin
        cnt_r <= cnt_r + 3'h1;
        done_r <= (cnt_r == igx_pkg::LAST_BIT);
      end
      if (state_r == igx_pkg::IGX_RACK) begin
        mack_r <= ~pins.sda;
      end
    end else if (pins.scl_fall) begin
      done_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Protocol state machine, advances on falling bus clock
  // ****************************************************************
  // Reset idles the machine and releases the data wire.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= igx_pkg::IGX_IDLE;
      sda_oe_r <= 1'b0;
      shift_r <= 8'h00;
      ptr_r <= igx_pkg::PTR_RST;
    end else if (pins.stop) begin
      state_r <= igx_pkg::IGX_IDLE;
      sda_oe_r <= 1'b0;
    end else if (pins.start) begin
      // A repeated start keeps the pointer for a following read.
      state_r <= igx_pkg::IGX_ADDR;
      sda_oe_r <= 1'b0;
    end else if (pins.scl_rise && in_state_byte && (state_r != igx_pkg::IGX_RDATA)) begin
      shift_r <= {shift_r[6:0], pins.sda};
    end else if (pins.scl_fall) begin
      unique case (state_r)
        igx_pkg::IGX_IDLE: ; // Every way into idle has already released the data wire.
        igx_pkg::IGX_ADDR: begin
          if (done_r && addr_hit) begin
            state_r <= igx_pkg::IGX_ACK_ADDR;
            sda_oe_r <= 1'b1;
          end else if (done_r) begin
            // Another target's address: stay silent until next start.
            state_r <= igx_pkg::IGX_IDLE;
          end
        end
        igx_pkg::IGX_ACK_ADDR: begin
          if (is_read) begin
            // Read: first data bit goes out on this same edge.
            state_r <= igx_pkg::IGX_RDATA;
            shift_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
          end else begin
            state_r <= igx_pkg::IGX_CMD;
            sda_oe_r <= 1'b0;
          end
        end
        igx_pkg::IGX_CMD: begin
          if (done_r) begin
            // Only the low three bits select a register.
            ptr_r <= shift_r[igx_pkg::PTR_W-1:0];
            state_r <= igx_pkg::IGX_ACK_CMD;
            sda_oe_r <= 1'b1;
          end
        end
        igx_pkg::IGX_ACK_CMD: begin
          state_r <= igx_pkg::IGX_WDATA;
          sda_oe_r <= 1'b0;
        end
        igx_pkg::IGX_WDATA: begin
          if (done_r) begin
            state_r <= igx_pkg::IGX_ACK_WDATA;
            sda_oe_r <= 1'b1;
          end
        end
        igx_pkg::IGX_ACK_WDATA: begin
          ptr_r <= ptr_next;
          state_r <= igx_pkg::IGX_WDATA;
          sda_oe_r <= 1'b0;
        end
        igx_pkg::IGX_RDATA: begin
          if (done_r) begin
            state_r <= igx_pkg::IGX_RACK;
            sda_oe_r <= 1'b0;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_r <= ~shift_r[6];
          end
        end
        igx_pkg::IGX_RACK: begin
          if (mack_r) begin
            // Master wants more: next register of the pair.
            ptr_r <= ptr_next;
            state_r <= igx_pkg::IGX_RDATA;
            shift_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
          end else begin
            state_r <= igx_pkg::IGX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Input registers are not stored, so writes to them drop; latches hold.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      out_r <= '{igx_pkg::OUT_RST, igx_pkg::OUT_RST};
      pol_r <= '{igx_pkg::POL_RST, igx_pkg::POL_RST};
      cfg_r <= '{igx_pkg::CFG_RST, igx_pkg::CFG_RST};
    end else if (wr_en) begin
      if (grp_sel == igx_pkg::GRP_OUT) begin
        out_r[port_sel] <= shift_r;
      end
      if (grp_sel == igx_pkg::GRP_POL) begin
        pol_r[port_sel] <= shift_r;
      end
      if (grp_sel == igx_pkg::GRP_CFG) begin
        cfg_r[port_sel] <= shift_r;
      end
    end
  end

  // ****************************************************************
  // Change detect and interrupt
  // ****************************************************************
  // Snapshot follows the pins at start-up and on each input read. The
  // comparison uses raw levels, so polarity changes never raise it.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      init_r <= 1'b1;
      snap_r <= '{8'h00, 8'h00};
      int_r <= 1'b0;
    end else begin
      init_r <= 1'b0;
      if (init_r) begin
        snap_r <= '{pins.pin_lo, pins.pin_hi};
      end else if (snap_ld) begin
        snap_r[port_sel] <= pin_sel;
      end
      // A read clears only its own port, so a change on the other port still sets.
      int_r <= !init_r && (|mis_left);
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Open-drain: the driven level is always low, only the enable moves.
  assign int_o_out = 1'b0;
  assign int_oe_out = int_r;
  assign sda_o_out = 1'b0;
  assign sda_oe_out = sda_oe_r;
  // Enables come straight from reset-valued flops, so no pulse at start.
  assign port_lo_out = out_r[0];
  assign port_hi_out = out_r[1];
  assign port_lo_oe_out = ~cfg_r[0];
  assign port_hi_oe_out = ~cfg_r[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_INT_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (|mismatch) && !init_r && !snap_ld |=> int_oe_out) else $error("Pin change missed.");
  AST_INT_OD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    int_o_out == 1'b0) else $error("Interrupt pin drove high.");
  AST_RST_DEF: assert property (@(posedge clk_sys_in) rst_in |=>
    state_r == igx_pkg::IGX_IDLE && out_r[1] == igx_pkg::OUT_RST &&
    pol_r[0] == igx_pkg::POL_RST && !sda_oe_out) else $error("Reset defaults not loaded.");
  AST_ADDR_MISS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pins.scl_fall && done_r && state_r == igx_pkg::IGX_ADDR && !addr_hit && !pins.start &&
    !pins.stop |=> state_r == igx_pkg::IGX_IDLE && !sda_oe_out) else $error("Foreign ack.");
  AST_ALL_IN: assert property (@(posedge clk_sys_in) rst_in |=>
    port_lo_oe_out == 8'h00 && port_hi_oe_out == 8'h00) else $error("Output on after reset.");
  AST_CFG_WR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_en && grp_sel == igx_pkg::GRP_CFG && !port_sel |=> port_lo_oe_out == ~$past(shift_r))
    else $error("Direction write not applied.");
  AST_LATCH: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !wr_en |=> $stable(port_lo_out) && $stable(port_hi_out)) else $error("Latch moved.");
  AST_IDLE_QUIET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_r == igx_pkg::IGX_IDLE |-> !sda_oe_out) else $error("Data wire pulled while idle.");
  AST_PTR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_r == igx_pkg::IGX_CMD && pins.scl_fall && done_r && !pins.start && !pins.stop |=>
    ptr_r == $past(shift_r[2:0]) ##1 state_r == igx_pkg::IGX_ACK_CMD) else $error("No pointer.");
  AST_INT_CLR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    snap_ld && (port_sel ? pins.pin_lo == snap_r[0] : pins.pin_hi == snap_r[1]) |=> !int_oe_out)
    else $error("Input read did not release interrupt.");
endmodule

// >>> test/igx_master_model.sv
// Behavioural bus master driving the expander's serial clock and data.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
module igx_master_model (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in
);
  // ******
  // Bus timing
  // ******
  // One bit takes 80 ns. That is faster than fast mode, traded for a short run.
  // The target oversamples at 200 MHz. Data moves 25 ns after a clock fall,
  // so it lands after the target's synchronised clock has fallen.
  initial begin
    scl_out = 1'b1; // The clock stands high outside frames.
    sda_oe_out = 1'b0; // Data is released while idle.
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic bus_start();
    #25 sda_oe_out = 1'b0;
    #15 scl_out = 1'b1;
    #20 sda_oe_out = 1'b1;
    #20 scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic bus_stop();
    #25 sda_oe_out = 1'b1;
    #15 scl_out = 1'b1;
    #20 sda_oe_out = 1'b0;
    #20;
  endtask

  // One bit: drive low for a 0, release for a 1, sample the wire while high.
  task automatic bus_bit(input logic b, output logic seen);
    #25 sda_oe_out = ~b;
    #15 scl_out = 1'b1;
    #20 seen = sda_in;
    #20 scl_out = 1'b0;
  endtask

  // Sends a byte, most significant bit first, and reports the target's ack.
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(v[i], s);
    end
    bus_bit(1'b1, s);
    ack = ~s;
  endtask

  // Receives a byte; the last one of a read is answered with a no-ack.
  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, v[i]);
    end
    bus_bit(last, s);
  endtask
endmodule

// >>> test/test_i2c_gpio_expander_16bit.sv
// Self-checking bench for the 16-line serial GPIO expander.
// Assumes the package, interface, design and bus master model compile first.
`timescale 1ns/100ps
module test_i2c_gpio_expander_16bit;
  // ******
  // Wiring
  // ******
  logic clk_sys_in = 1'b0; // System clock.
  logic rst_in = 1'b1; // Reset, held for five edges.
  logic [2:0] strap = 3'h0; // Address straps.
  logic [15:0] ext = 16'h0000; // Board levels on undriven lines.
  logic [15:0] lfsr_r = 16'h8611; // Seed 34321.
  int err_total = 0;
  int checks_done = 0;
  logic scl, m_oe, sda_o, sda_oe, int_o, int_oe;
  logic [7:0] lo_out, lo_oe, hi_out, hi_oe;
  // Pull-ups: a released wire reads high.
  wire sda_w = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  wire int_w = int_oe ? int_o : 1'b1;
  wire [15:0] oe = {hi_oe, lo_oe};
  wire [15:0] pins = (oe & {hi_out, lo_out}) | (~oe & ext);

  always #2.5 clk_sys_in = ~clk_sys_in;

  igx_master_model igx_master_model_i (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda_w));
  igx_expander igx_expander_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_o_out(sda_o), .sda_oe_out(sda_oe), .int_o_out(int_o),
    .int_oe_out(int_oe), .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]),
    .addr_strap_bit2_in(strap[2]), .port_lo_in(pins[7:0]), .port_lo_out(lo_out),
    .port_lo_oe_out(lo_oe), .port_hi_in(pins[15:8]), .port_hi_out(hi_out),
    .port_hi_oe_out(hi_oe));

  // ******
  // Helpers
  // ******
  function automatic logic [15:0] lfsr_step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Sixteen steps per draw so that successive values are not shifted copies.
  task automatic rnd(output logic [15:0] v);
    repeat (16) lfsr_r = lfsr_step(lfsr_r);
    v = lfsr_r;
  endtask

  // Input register: pin level, outputs looping back, then polarity applied.
  function automatic logic [15:0] exp_in(input logic [15:0] o, c, e, p);
    return ((~c & o) | (c & e)) ^ p;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One framed transfer of two bytes; ack is low if any byte went unanswered.
  task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input logic rd,
      input logic [15:0] wd, output logic [15:0] rdat, output logic ack);
    logic k0, k1, k2, k3;
    igx_master_model_i.bus_start();
    igx_master_model_i.send_byte({a, 1'b0}, k0);
    igx_master_model_i.send_byte(cmd, k1);
    if (rd) begin
      igx_master_model_i.bus_start();
      igx_master_model_i.send_byte({a, 1'b1}, k2);
      igx_master_model_i.recv_byte(1'b0, rdat[7:0]);
      igx_master_model_i.recv_byte(1'b1, rdat[15:8]);
      k3 = 1'b1;
    end else begin
      igx_master_model_i.send_byte(wd[7:0], k2);
      igx_master_model_i.send_byte(wd[15:8], k3);
    end
    igx_master_model_i.bus_stop();
    ack = k0 & k1 & k2 & k3;
    tick(2);
  endtask

  // Waits, bounded, for the interrupt wire to reach a level.
  task automatic wait_int(input logic lvl, output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 20 && !ok; k++) begin
      tick(1);
      ok = (int_w === lvl);
    end
  endtask

  task automatic complete_run();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Six rounds take about 210 us of bus traffic; reaching 300 us means a hang.
  initial begin
    #300_000;
    err_total++;
    complete_run();
  end

  // ******
  // Tests
  // ******
  initial begin
    logic [15:0] o, p, c, rd;
    logic [6:0] adr;
    logic ak, ok;
    tick(2);
    chk({oe, hi_out, lo_out}, 32'h0000_FFFF);
    tick(3);
    rst_in = 1'b0;
    tick(10);
    chk(32'(int_w), 32'h1);
    $display("reset test done, mismatches %0d", err_total);
    for (int it = 0; it < 6; it++) begin
      rnd(o);
      rnd(p);
      rnd(c);
      rnd(ext);
      rnd(rd);
      // Corner cases first: all outputs but one line, then all inputs.
      c = (it < 2) ? (it ? 16'hFFFF : 16'h0001) : (c | 16'h0001);
      strap = rd[2:0];
      adr = {igx_pkg::ADDR_HI, strap};
      xfer(adr, 8'h02, 1'b0, o, rd, ak);
      chk(32'(ak), 32'h1);
      xfer(adr, 8'h04, 1'b0, p, rd, ak);
      chk(32'(ak), 32'h1);
      xfer(adr, 8'hF6, 1'b0, c, rd, ak);
      chk(32'(ak), 32'h1);
      chk({oe, hi_out, lo_out}, {~c, o});
      xfer(adr ^ 7'h01, 8'h06, 1'b0, ~c, rd, ak);
      chk(32'(ak), 32'h0);
      xfer(adr, 8'h00, 1'b0, ~o, rd, ak);
      chk({oe, hi_out, lo_out}, {~c, o});
      xfer(adr, 8'h02, 1'b1, 16'h0000, rd, ak);
      chk(32'(rd), 32'(o));
      xfer(adr, 8'h05, 1'b1, 16'h0000, rd, ak);
      chk(32'(rd), {16'h0000, p[7:0], p[15:8]});
      xfer(adr, 8'h06, 1'b1, 16'h0000, rd, ak);
      chk(32'(rd), 32'(c));
      xfer(adr, 8'h00, 1'b1, 16'h0000, rd, ak);
      chk(32'(rd), 32'(exp_in(o, c, ext, p)));
      chk(32'(int_w), 32'h1);
      ext[0] = ~ext[0];
      wait_int(1'b0, ok);
      chk(32'(ok), 32'h1);
      ext[0] = ~ext[0];
      wait_int(1'b1, ok);
      chk(32'(ok), 32'h1);
      ext[0] = ~ext[0];
      wait_int(1'b0, ok);
      xfer(adr, 8'h00, 1'b1, 16'h0000, rd, ak);
      chk({int_w, 15'h0000, rd}, {1'b1, 15'h0000, exp_in(o, c, ext, p)});
      ext[0] = ~ext[0];
      $display("round %0d done, mismatches %0d", it, err_total);
    end
    complete_run();
  end
endmodule
